// ===== src/rss_regs.svh
`ifndef RSS_REGS_SVH
`define RSS_REGS_SVH
// register indices, chosen for this block
`define RSS_ADDR_CTRL      4'h0
`define RSS_ADDR_STOP      4'h1
`define RSS_ADDR_BRAKE     4'h2
`define RSS_ADDR_FREQ      4'h3
`define RSS_ADDR_BBLOCK    4'h4
`define RSS_ADDR_STATUS    4'h5
`define RSS_ADDR_OUTFREQ   4'h6
// field positions of the control register
`define RSS_CTRL_SRC       0
`define RSS_CTRL_FLUX      1
`define RSS_CTRL_3WIRE     2
`define RSS_CTRL_KRUN      3
`define RSS_CTRL_KSTOP     4
`define RSS_CTRL_KREV      5
`define RSS_CTRL_KJOG      6
// reset values
`define RSS_SRC_RST        1'b1
`define RSS_STOP_RST       2'h0
`define RSS_BMIN_RST       2'h0
`define RSS_BSF_RST        8'h05
`define RSS_BCUR_RST       7'h32
`define RSS_BSTART_RST     10'h000
`define RSS_BSTOP_RST      10'h032
`define RSS_MINF_RST       8'h05
`define RSS_MAXF_RST       10'h258
`define RSS_NLC_RST        7'h1e
`define RSS_BBLK_RST       10'h032
// limits in register units
`define RSS_BSF_MAX        8'h64
`define RSS_BCUR_MAX       7'h64
`define RSS_BTIME_MAX      10'h3e8
// timing: 10 ms tick, 50 ms latch hold
`define RSS_TICK_NS        10000000
`define RSS_CLK_NS         8
`define RSS_TICK_CYC       ((`RSS_TICK_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_HOLD_MS        50
`define RSS_HOLD_CYC       ((`RSS_HOLD_MS * 1000000 + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_TIME_SCALE     10
`endif

// ===== src/rss_pkg.sv
package rss_pkg;
  typedef enum logic [2:0] {
    RSS_IDLE   = 3'b000,
    RSS_STARTDC= 3'b001,
    RSS_RUN    = 3'b010,
    RSS_RAMP   = 3'b011,
    RSS_BBLOCK = 3'b100,
    RSS_DCINJ  = 3'b101,
    RSS_COAST  = 3'b110
  } rss_state_type;
  typedef struct packed {
    logic       valid;
    logic [3:0] addr;
    logic [15:0] wdata;
  } rss_wr_type;
  typedef struct packed {
    logic fwd;
    logic rev;
    logic dir_sel;
  } rss_term_type;
endpackage

// ===== src/rss_run_stop_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "rss_regs.svh"
module rss_run_stop_sequencer (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               srst,
  input  wire logic               clk_en,
  // register port
  input  wire rss_pkg::rss_wr_type wr,
  input  wire logic               rd_stb,
  input  wire logic [3:0]         rd_addr,
  output logic [15:0]             rd_data,
  // terminals, output frequency and reference, ramp status
  input  wire rss_pkg::rss_term_type term,
  input  wire logic [9:0]         out_freq,
  input  wire logic [9:0]         freq_ref,
  input  wire logic               ramp_done,
  // drive commands
  output logic                    run_cmd,
  output logic                    rev_cmd,
  output logic                    jog_cmd,
  output logic                    out_enable,
  output logic                    dc_inj,
  output logic [6:0]              dc_current,
  output logic [9:0]              freq_target
);
  import rss_pkg::*;

  logic          src_reg;
  logic          flux_reg;
  logic          three_reg;
  logic          krun_reg;
  logic          kstop_reg;
  logic          krev_reg;
  logic          kjog_reg;
  logic [1:0]    stop_reg;
  logic [1:0]    bmin_reg;
  logic [7:0]    bsf_reg;
  logic [6:0]    bcur_reg;
  logic [9:0]    bstart_reg;
  logic [9:0]    bstop_reg;
  logic [7:0]    minf_reg;
  logic [9:0]    maxf_reg;
  logic [6:0]    nlc_reg;
  logic [9:0]    bblk_reg;
  rss_state_type state_reg;
  rss_state_type state_next;
  logic [20:0]   tick_cnt_reg;
  logic          tick;
  logic [23:0]   hold_cnt_reg;
  logic          latch_reg;
  logic [9:0]    time_reg;
  logic [9:0]    stopf_reg;
  logic          want_run;
  logic          want_rev;
  logic          term_run;
  logic          term_rev;
  logic [1:0]    stop_eff;
  logic [7:0]    brk_freq;
  logic [23:0]   dc_prod;
  logic [23:0]   dc_time;
  logic          time_zero;

  // configuration writes; brake current, brake start freq and start/stop times clip to their limits, others stored as written but stop methods 2/3 in flux vector
  always_ff @(posedge core_clk) begin
    if (srst) begin
      src_reg    <= `RSS_SRC_RST;
      flux_reg   <= 1'b0;
      three_reg  <= 1'b0;
      stop_reg   <= `RSS_STOP_RST;
      bmin_reg   <= `RSS_BMIN_RST;
      bsf_reg    <= `RSS_BSF_RST;
      bcur_reg   <= `RSS_BCUR_RST;
      bstart_reg <= `RSS_BSTART_RST;
      bstop_reg  <= `RSS_BSTOP_RST;
      minf_reg   <= `RSS_MINF_RST;
      maxf_reg   <= `RSS_MAXF_RST;
      nlc_reg    <= `RSS_NLC_RST;
      bblk_reg   <= `RSS_BBLK_RST;
    end else if (clk_en && wr.valid) begin
      case (wr.addr)
        `RSS_ADDR_CTRL: begin
          src_reg   <= wr.wdata[`RSS_CTRL_SRC];
          flux_reg  <= wr.wdata[`RSS_CTRL_FLUX];
          three_reg <= wr.wdata[`RSS_CTRL_3WIRE];
        end
        `RSS_ADDR_STOP: begin
          // flux vector keeps only ramp and coast
          if (!flux_reg || !wr.wdata[1])
            stop_reg <= wr.wdata[1:0];
          bmin_reg <= wr.wdata[5:4];
        end
        `RSS_ADDR_BRAKE: begin
          bcur_reg <= (wr.wdata[6:0] > `RSS_BCUR_MAX) ? `RSS_BCUR_MAX
                                                      : wr.wdata[6:0];
          bsf_reg  <= (wr.wdata[15:8] > `RSS_BSF_MAX) ? `RSS_BSF_MAX
                                                      : wr.wdata[15:8];
        end
        `RSS_ADDR_FREQ: begin
          minf_reg <= wr.wdata[7:0];
          nlc_reg  <= wr.wdata[14:8];
        end
        `RSS_ADDR_BBLOCK: bblk_reg <= wr.wdata[9:0];
        `RSS_ADDR_OUTFREQ: maxf_reg <= wr.wdata[9:0];
        `RSS_ADDR_STATUS: begin
          bstart_reg <= (wr.wdata[9:0] > `RSS_BTIME_MAX) ? `RSS_BTIME_MAX
                                                         : wr.wdata[9:0];
        end
        default: begin
          bstop_reg <= (wr.wdata[9:0] > `RSS_BTIME_MAX) ? `RSS_BTIME_MAX
                                                        : wr.wdata[9:0];
        end
      endcase
    end
  end

  // keypad key levels, written by software on behalf of the operator
  always_ff @(posedge core_clk) begin
    if (srst) begin
      krun_reg  <= 1'b0;
      kstop_reg <= 1'b0;
      krev_reg  <= 1'b0;
      kjog_reg  <= 1'b0;
    end else if (clk_en && wr.valid && wr.addr == `RSS_ADDR_CTRL) begin
      krun_reg  <= wr.wdata[`RSS_CTRL_KRUN];
      kstop_reg <= wr.wdata[`RSS_CTRL_KSTOP];
      krev_reg  <= wr.wdata[`RSS_CTRL_KREV];
      kjog_reg  <= wr.wdata[`RSS_CTRL_KJOG];
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_data <= 16'h0000;
    end else if (clk_en) begin
      rd_data <= 16'h0000;
      if (rd_stb) begin
        case (rd_addr)
          `RSS_ADDR_CTRL:
            rd_data <= {9'h000, kjog_reg, krev_reg, kstop_reg, krun_reg,
                        three_reg, flux_reg, src_reg};
          `RSS_ADDR_STOP:    rd_data <= {10'h000, bmin_reg, 2'h0, stop_reg};
          `RSS_ADDR_BRAKE:   rd_data <= {bsf_reg, 1'b0, bcur_reg};
          `RSS_ADDR_FREQ:    rd_data <= {1'b0, nlc_reg, minf_reg};
          `RSS_ADDR_BBLOCK:  rd_data <= {6'h00, bblk_reg};
          `RSS_ADDR_OUTFREQ: rd_data <= {6'h00, maxf_reg};
          `RSS_ADDR_STATUS:
            rd_data <= {latch_reg, state_reg, 2'h0, time_reg};
          default:           rd_data <= {6'h00, bstop_reg};
        endcase
      end
    end
  end

  // 10 ms timebase, free running
  assign tick = (tick_cnt_reg == 21'(`RSS_TICK_CYC - 1));
  always_ff @(posedge core_clk) begin
    if (srst)
      tick_cnt_reg <= 21'h000000;
    else if (clk_en)
      tick_cnt_reg <= tick ? 21'h000000 : tick_cnt_reg + 21'h000001;
  end

  // 3-wire run latch: forward closed for the hold time sets, stop opens it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hold_cnt_reg <= 24'h000000;
      latch_reg    <= 1'b0;
    end else if (clk_en) begin
      if (!term.fwd)
        hold_cnt_reg <= 24'h000000;
      else if (hold_cnt_reg != 24'(`RSS_HOLD_CYC))
        hold_cnt_reg <= hold_cnt_reg + 24'h000001;
      // rev terminal acts as the normally-closed stop contact in 3-wire
      if (!term.rev || !three_reg)
        latch_reg <= 1'b0;
      else if (hold_cnt_reg == 24'(`RSS_HOLD_CYC))
        latch_reg <= 1'b1;
    end
  end

  // run request by source and sequence
  always_comb begin
    if (three_reg) begin
      term_run = latch_reg;
      term_rev = term.dir_sel;
    end else begin
      term_run = term.fwd ^ term.rev;
      term_rev = term.rev;
    end
    if (src_reg) begin
      want_run = term_run;
      want_rev = term_rev;
    end else begin
      want_run = (krun_reg || kjog_reg) && !kstop_reg;
      want_rev = krev_reg;
    end
  end

  // effective stop method and brake frequency
  assign stop_eff  = flux_reg ? {1'b0, stop_reg[0]} : stop_reg;
  assign brk_freq  = (bsf_reg < minf_reg) ? minf_reg : bsf_reg;
  assign dc_prod   = 24'(bstop_reg) * 24'(`RSS_TIME_SCALE) * 24'(stopf_reg);
  // full width: a small max freq must clip, not wrap, the stop time
  assign dc_time   = dc_prod / 24'(maxf_reg == 10'h000 ? 10'h001
                                                    : maxf_reg);
  assign time_zero = (time_reg == 10'h000);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RSS_IDLE:
        if (want_run)
          state_next = (bstart_reg != 10'h000) ? RSS_STARTDC : RSS_RUN;
      RSS_STARTDC:
        if (!want_run)     state_next = RSS_IDLE;
        else if (time_zero) state_next = RSS_RUN;
      RSS_RUN:
        if (!want_run) begin
          case (stop_eff)
            2'h0:    state_next = RSS_RAMP;
            2'h1:    state_next = RSS_IDLE;
            2'h2:    state_next = RSS_BBLOCK;
            default: state_next = RSS_COAST;
          endcase
        end
      RSS_RAMP:
        if (want_run)
          state_next = RSS_RUN;
        else if (ramp_done || out_freq < {2'h0, brk_freq})
          state_next = RSS_DCINJ;
      RSS_BBLOCK:
        if (time_zero) state_next = RSS_DCINJ;
      RSS_DCINJ:
        if (time_zero) state_next = RSS_IDLE;
      RSS_COAST:
        if (time_zero) state_next = RSS_IDLE;
      default: state_next = RSS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst)
      state_reg <= RSS_IDLE;
    else if (clk_en)
      state_reg <= state_next;
  end

  // interval timer in 10 ms units, loaded on each state entry
  always_ff @(posedge core_clk) begin
    if (srst) begin
      time_reg  <= 10'h000;
      stopf_reg <= 10'h000;
    end else if (clk_en) begin
      if (state_next != state_reg) begin
        case (state_next)
          RSS_STARTDC: time_reg <= bstart_reg;
          RSS_BBLOCK:  time_reg <= bblk_reg;
          RSS_COAST:   time_reg <= bblk_reg;
          RSS_DCINJ:
            // dc-stop time scales with frequency after baseblock, else bstop_reg; clipped to RSS_BTIME_MAX
            time_reg <= (state_reg == RSS_BBLOCK)
                        ? ((dc_time > 24'(`RSS_BTIME_MAX)) ? `RSS_BTIME_MAX
                                                           : dc_time[9:0])
                        : bstop_reg;
          default:     time_reg <= 10'h000;
        endcase
        if (state_reg == RSS_RUN)
          stopf_reg <= out_freq;
      end else if (tick && !time_zero) begin
        time_reg <= time_reg - 10'h001;
      end
    end
  end

  // drive outputs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      run_cmd     <= 1'b0;
      rev_cmd     <= 1'b0;
      jog_cmd     <= 1'b0;
      out_enable  <= 1'b0;
      dc_inj      <= 1'b0;
      dc_current  <= 7'h00;
      freq_target <= 10'h000;
    end else if (clk_en) begin
      run_cmd    <= (state_next == RSS_RUN);
      out_enable <= (state_next == RSS_RUN) || (state_next == RSS_RAMP) ||
                    (state_next == RSS_STARTDC) || (state_next == RSS_DCINJ);
      dc_inj     <= (state_next == RSS_STARTDC) || (state_next == RSS_DCINJ);
      dc_current <= flux_reg ? nlc_reg : bcur_reg;
      if (state_next == RSS_RUN)
        rev_cmd <= want_rev;
      jog_cmd    <= !src_reg && kjog_reg;
      freq_target <= freq_ref;
      if (flux_reg && freq_ref < {2'h0, minf_reg}) begin
        case (bmin_reg)
          2'h1: begin
            out_enable  <= 1'b0;
            freq_target <= 10'h000;
          end
          2'h2:    freq_target <= {2'h0, minf_reg};
          2'h3:    freq_target <= 10'h000;
          default: freq_target <= freq_ref;
        endcase
      end
    end
  end

  property p_coast_ignore;
    @(posedge core_clk) disable iff (srst)
      (clk_en && state_reg == RSS_COAST && !time_zero) |=> !run_cmd;
  endproperty
  a_coast_ignore: assert property (p_coast_ignore)
    else $error("run accepted during coast timer");

  property p_flux_stop;
    @(posedge core_clk) disable iff (srst)
      (clk_en && flux_reg && state_reg == RSS_RUN) |=>
        (state_reg != RSS_BBLOCK && state_reg != RSS_COAST);
  endproperty
  a_flux_stop: assert property (p_flux_stop)
    else $error("dc or timer stop used in flux vector");

  property p_both_closed;
    @(posedge core_clk) disable iff (srst)
      (clk_en && src_reg && !three_reg && term.fwd && term.rev) |-> !want_run;
  endproperty
  a_both_closed: assert property (p_both_closed)
    else $error("both run terminals gave a run");

  property p_key_only;
    @(posedge core_clk) disable iff (srst)
      (!src_reg && !krun_reg && !kjog_reg) |-> !want_run;
  endproperty
  a_key_only: assert property (p_key_only)
    else $error("run without keypad key");

  sequence s_bblock_wait;
    state_reg == RSS_BBLOCK && !time_zero;
  endsequence
  property p_bblock;
    @(posedge core_clk) disable iff (srst)
      s_bblock_wait |=> !dc_inj;
  endproperty
  a_bblock: assert property (p_bblock)
    else $error("injection before baseblock time");

  property p_brk_floor;
    @(posedge core_clk) disable iff (srst)
      (clk_en && state_reg == RSS_RAMP && !want_run &&
       out_freq < {2'h0, minf_reg}) |=> dc_inj;
  endproperty
  a_brk_floor: assert property (p_brk_floor)
    else $error("no injection below minimum frequency");

  property p_dc_cur;
    @(posedge core_clk) disable iff (srst)
      (clk_en && !flux_reg) |=> (dc_current == $past(bcur_reg));
  endproperty
  a_dc_cur: assert property (p_dc_cur)
    else $error("wrong injection current");

  property p_two_wire_fwd;
    @(posedge core_clk) disable iff (srst)
      (src_reg && !three_reg && term.fwd && !term.rev) |-> want_run;
  endproperty
  a_two_wire_fwd: assert property (p_two_wire_fwd)
    else $error("forward terminal did not request run");
endmodule
`default_nettype wire

// ===== tb/rss_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
// contact-closure terminals; open contact reads 0, never left unknown
module rss_panel_model #(
  parameter int HOLD_CYC = 3
) (
  // clock
  input  wire logic           core_clk,
  // requests from the bench
  input  wire logic           fwd_req,
  input  wire logic           rev_req,
  input  wire logic           dir_req,
  input  wire logic           slow,
  // terminals
  output var rss_pkg::rss_term_type term
);
  import rss_pkg::*;
  logic fwd_d = 1'b0;
  logic rev_d = 1'b0;
  logic dir_d = 1'b0;
  logic fwd_q = 1'b0;
  logic rev_q = 1'b0;
  logic dir_q = 1'b0;
  int   hold_cnt = 0;
  // slow contacts settle one cycle later than prompt ones
  always @(posedge core_clk) begin
    fwd_d <= fwd_req;
    rev_d <= rev_req;
    dir_d <= dir_req;
  end
  always @(posedge core_clk) begin
    rev_q <= slow ? rev_d : rev_req;
    dir_q <= slow ? dir_d : dir_req;
    // a fwd press is stretched to at least HOLD_CYC cycles
    if ((slow ? fwd_d : fwd_req) && !fwd_q) begin
      hold_cnt <= HOLD_CYC;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
    fwd_q <= (slow ? fwd_d : fwd_req) || (hold_cnt > 1);
  end
  assign term = '{fwd: fwd_q, rev: rev_q, dir_sel: dir_q};
endmodule
`default_nettype wire

// ===== tb/rss_run_stop_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rss_regs.svh"
module rss_run_stop_sequencer_bench;
  import rss_pkg::*;
  logic         core_clk;
  logic         srst;
  logic         clk_en;
  rss_wr_type   wr;
  logic         rd_stb;
  logic [3:0]   rd_addr;
  logic [15:0]  rd_data;
  rss_term_type term;
  logic [9:0]   out_freq;
  logic [9:0]   freq_ref;
  logic         ramp_done;
  logic         run_cmd;
  logic         rev_cmd;
  logic         jog_cmd;
  logic         out_enable;
  logic         dc_inj;
  logic [6:0]   dc_current;
  logic [9:0]   freq_target;
  logic         fwd_req;
  logic         rev_req;
  logic         dir_req;
  logic         slow;
  logic [31:0]  rnd;
  logic [9:0]   fr;
  int           err_count;
  int           checks;
  int           cyc;

  rss_run_stop_sequencer i_dut (
    .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .wr(wr),
    .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data), .term(term),
    .out_freq(out_freq), .freq_ref(freq_ref), .ramp_done(ramp_done),
    .run_cmd(run_cmd), .rev_cmd(rev_cmd), .jog_cmd(jog_cmd),
    .out_enable(out_enable), .dc_inj(dc_inj), .dc_current(dc_current),
    .freq_target(freq_target)
  );
  rss_panel_model #(.HOLD_CYC(3)) i_panel (
    .core_clk(core_clk), .fwd_req(fwd_req), .rev_req(rev_req),
    .dir_req(dir_req), .slow(slow), .term(term)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // target under a low reference in flux mode, every code
  function automatic logic [9:0] exp_target(input int c, logic [9:0] r);
    return (c == 2) ? {2'b00, `RSS_MINF_RST} : (c == 0) ? r : 10'h000;
  endfunction

  task automatic print_verdict;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_reg({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    wr <= '{valid: 1'b1, addr: a, wdata: d};
    @(posedge core_clk);
    wr.valid <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe, 0 after it
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    rd_stb  <= 1'b1;
    rd_addr <= a;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    #1;
    chk_reg(rd_data, exp);
    @(posedge core_clk);
    #1;
    chk_reg(rd_data, 16'h0000);
  endtask
  task automatic set_term(input logic f, input logic r);
    @(posedge core_clk);
    fwd_req <= f;
    rev_req <= r;
  endtask
  task automatic settle;
    repeat (6) @(posedge core_clk);
    #1;
  endtask
  // mid-run reset, then source/mode bits and baseblock time
  task automatic setup(input logic [15:0] ctrl, input logic [15:0] bblk);
    set_term(1'b0, 1'b0);
    @(posedge core_clk);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    wr_reg(`RSS_ADDR_BBLOCK, bblk);
    wr_reg(`RSS_ADDR_CTRL, ctrl);
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    {srst, clk_en, rd_stb, rd_addr, ramp_done} = 8'h80;
    {fwd_req, rev_req, dir_req, slow, err_count, checks, cyc} = '0;
    wr = '0;
    out_freq = 10'h100;
    freq_ref = 10'h100;
    rnd = 32'hfca7;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    clk_en <= 1'b1;
    settle();
    chk_flag(run_cmd | out_enable | dc_inj, 1'b0);
    rd_chk(`RSS_ADDR_CTRL, {15'h0000, `RSS_SRC_RST});
    rd_chk(`RSS_ADDR_STOP, {10'h000, `RSS_BMIN_RST, 2'b00, `RSS_STOP_RST});
    rd_chk(`RSS_ADDR_BRAKE, {`RSS_BSF_RST, 1'b0, `RSS_BCUR_RST});
    rd_chk(`RSS_ADDR_FREQ, {1'b0, `RSS_NLC_RST, `RSS_MINF_RST});
    rd_chk(4'h7, {6'h00, `RSS_BSTOP_RST});
    // brake current and brake start freq writes within their limits are stored as written
    rd_chk(`RSS_ADDR_OUTFREQ, {6'h00, `RSS_MAXF_RST});
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      wr_reg(`RSS_ADDR_BRAKE, {rnd[15:8] % 8'd101, 1'b0, rnd[6:0] % 7'd101});
      rd_chk(`RSS_ADDR_BRAKE, {rnd[15:8] % 8'd101, 1'b0, rnd[6:0] % 7'd101});
    end
    // out-of-range settings clip to their limits
    wr_reg(`RSS_ADDR_BRAKE, 16'hff7f);
    rd_chk(`RSS_ADDR_BRAKE, {`RSS_BSF_MAX, 1'b0, `RSS_BCUR_MAX});
    wr_reg(4'h7, 16'h03ff);
    rd_chk(4'h7, {6'h00, `RSS_BTIME_MAX});
    // keypad source ignores the terminals
    setup(16'h0000, 16'h0000);
    wr_reg(`RSS_ADDR_STOP, 16'h0001);
    set_term(1'b1, 1'b0);
    settle();
    chk_flag(run_cmd, 1'b0);
    wr_reg(`RSS_ADDR_CTRL, 16'h0028);
    settle();
    chk_flag(run_cmd & rev_cmd, 1'b1);
    wr_reg(`RSS_ADDR_CTRL, 16'h0010);
    settle();
    chk_flag(out_enable, 1'b0);
    wr_reg(`RSS_ADDR_CTRL, 16'h0040);
    settle();
    chk_flag(jog_cmd, 1'b1);
    wr_reg(`RSS_ADDR_CTRL, 16'h0010);
    // terminal source, 2-wire, coast stop
    wr_reg(`RSS_ADDR_CTRL, 16'h0001);
    settle();
    chk_flag(run_cmd & out_enable & !rev_cmd, 1'b1);
    set_term(1'b0, 1'b0);
    settle();
    chk_flag(out_enable | run_cmd, 1'b0);
    slow <= 1'b1;
    set_term(1'b0, 1'b1);
    settle();
    chk_flag(rev_cmd & out_enable, 1'b1);
    set_term(1'b1, 1'b1);
    settle();
    chk_flag(run_cmd, 1'b0);
    slow <= 1'b0;
    set_term(1'b0, 1'b0);
    settle();
    @(posedge core_clk);
    clk_en <= 1'b0;
    set_term(1'b1, 1'b0);
    settle();
    chk_flag(run_cmd, 1'b0);
    @(posedge core_clk);
    clk_en <= 1'b1;
    settle();
    chk_flag(run_cmd, 1'b1);
    // 3-wire: a short forward press with stop closed latches no run
    setup(16'h0005, 16'h0000);
    dir_req <= 1'b1;
    set_term(1'b0, 1'b1);
    set_term(1'b1, 1'b1);
    settle();
    chk_flag(run_cmd | out_enable, 1'b0);
    rd_chk(`RSS_ADDR_STATUS, 16'h0000);
    // coast with timer and dc stop: a new run waits out the timer
    for (int m = 3; m > 1; m--) begin
      setup(16'h0001, 16'h03e8);
      wr_reg(`RSS_ADDR_STOP, m[15:0]);
      set_term(1'b1, 1'b0);
      settle();
      set_term(1'b0, 1'b0);
      settle();
      chk_flag(out_enable | dc_inj, 1'b0);
      set_term(1'b1, 1'b0);
      settle();
      chk_flag(run_cmd, 1'b0);
    end
    // start injection when a start time is set
    setup(16'h0001, 16'h0000);
    wr_reg(4'h5, 16'h0001);
    set_term(1'b1, 1'b0);
    settle();
    chk_flag(dc_inj, 1'b1);
    chk_reg({9'h000, dc_current}, {9'h000, `RSS_BCUR_RST});
    // flux mode refuses methods 2 and 3
    setup(16'h0003, 16'h0000);
    wr_reg(`RSS_ADDR_STOP, 16'h0001);
    for (int m = 2; m < 4; m++) begin
      wr_reg(`RSS_ADDR_STOP, m[15:0]);
      rd_chk(`RSS_ADDR_STOP, 16'h0001);
    end
    // ramp stop: start freq below minimum injects at the minimum
    setup(16'h0001, 16'h0000);
    wr_reg(`RSS_ADDR_BRAKE, 16'h0228);
    out_freq <= 10'h006;
    set_term(1'b1, 1'b0);
    settle();
    set_term(1'b0, 1'b0);
    settle();
    chk_flag(!dc_inj & out_enable & !run_cmd, 1'b1);
    @(posedge core_clk);
    out_freq <= 10'h004;
    settle();
    chk_flag(dc_inj, 1'b1);
    chk_reg({9'h000, dc_current}, 16'h0028);
    // flux: a dc stop chosen earlier falls back to ramp, no-load current
    setup(16'h0001, 16'h0000);
    wr_reg(`RSS_ADDR_STOP, 16'h0002);
    wr_reg(`RSS_ADDR_CTRL, 16'h0003);
    out_freq <= 10'h100;
    set_term(1'b1, 1'b0);
    settle();
    set_term(1'b0, 1'b0);
    ramp_done <= 1'b1;
    settle();
    chk_flag(dc_inj, 1'b1);
    chk_reg({9'h000, dc_current}, {9'h000, `RSS_NLC_RST});
    @(posedge core_clk);
    ramp_done <= 1'b0;
    // flux: every below-minimum code with a random low reference
    for (int c = 0; c < 4; c++) begin
      setup(16'h0003, 16'h0000);
      wr_reg(`RSS_ADDR_STOP, {10'h000, c[1:0], 4'h0});
      rnd = lfsr(rnd);
      fr = rnd[9:0] % 10'd5;
      freq_ref <= fr;
      set_term(1'b1, 1'b0);
      settle();
      chk_flag(out_enable, c != 1);
      chk_reg({6'h00, freq_target}, {6'h00, exp_target(c, fr)});
    end
    print_verdict();
  end
endmodule
`default_nettype wire
